// *** hw/ecd_clock_divider.sv ***
// sampling clock selector: nominal oscillator or divided pin clock,
// plus the acquisition timer that runs on the selected clock
// assumes config inputs come from mclk_i logic; the pin clock is asynchronous
`timescale 1ns/100ps
`include "ecd_defines.svh"
module ecd_clock_divider #(
    parameter int DIV_W = `ECD_DIV_W
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic pin_clock_select_i,
    input wire logic [DIV_W-1:0] clock_divide_field_i,
    input wire logic irq_req_i,
    input wire logic sync_clock_irq_pin_in_i,
    input wire logic acq_start_i,
    input wire logic acq_shunt_i,
    input wire ecd_pkg::ecd_setting_t bus_conversion_setting_i,
    input wire ecd_pkg::ecd_setting_t shunt_conversion_setting_i,
    output logic sync_clock_irq_pin_out_o,
    output logic sync_clock_irq_pin_oe_o,
    output logic osc_enable_o,
    output logic sys_clk_o,
    output logic sys_tick_o,
    output logic acq_busy_o,
    output logic acq_done_o
);

    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] OSC_HALF = CNT_W'(`ECD_OSC_HALF_CYC);

    // the divide value must fit the shared half period counter
    if (DIV_W < 1 || DIV_W > CNT_W - 1)
    begin
        $error("divide field width out of range");
    end

    typedef struct packed {
        logic clk_ff;
        logic tick_ff;
        logic act_ext_ff;
        logic [DIV_W-1:0] act_div_ff;
        logic [CNT_W-1:0] half_cnt_ff;
        ecd_pkg::ecd_acq_e acq_ff;
        logic [CNT_W-1:0] acq_cnt_ff;
        logic done_ff;
        logic osc_en_ff;
        logic pin_oe_ff;
        logic pin_out_ff;
    } ecd_state_s;

    ecd_state_s st_ff;
    ecd_state_s nxt_st;
    logic pin_rise;
    logic half_end;
    ecd_pkg::ecd_setting_t cur_set;
    logic [CNT_W-1:0] acq_len;

    // the filtering front end stands in for the pin's schmitt buffer
    ecd_pin_sync u_pin_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .async_i(sync_clock_irq_pin_in_i),
        .level_o(),
        .rise_o(pin_rise)
    );

    always_comb
    begin
        cur_set = acq_shunt_i ? shunt_conversion_setting_i : bus_conversion_setting_i;
        unique case (cur_set)
            2'h0: acq_len = CNT_W'(`ECD_ACQ_TICKS_0);
            2'h1: acq_len = CNT_W'(`ECD_ACQ_TICKS_1);
            2'h2: acq_len = CNT_W'(`ECD_ACQ_TICKS_2);
            2'h3: acq_len = CNT_W'(`ECD_ACQ_TICKS_3);
        endcase
    end

    // half period ends after OSC_HALF mclk cycles, or after field+1 pin edges
    assign half_end = st_ff.act_ext_ff ? (st_ff.half_cnt_ff == CNT_W'(st_ff.act_div_ff))
                                       : (st_ff.half_cnt_ff == OSC_HALF - 9'h001);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick_ff = 1'b0;
        nxt_st.done_ff = 1'b0;
        nxt_st.osc_en_ff = ~pin_clock_select_i;
        nxt_st.pin_oe_ff = ~pin_clock_select_i;
        nxt_st.pin_out_ff = ~irq_req_i;
        if (!st_ff.act_ext_ff || pin_rise)
        begin
            if (half_end)
            begin
                nxt_st.half_cnt_ff = '0;
                nxt_st.clk_ff = ~st_ff.clk_ff;
                nxt_st.tick_ff = ~st_ff.clk_ff;
                // new source and divide take effect only on a falling edge,
                // so every high and low phase is whole; a silent pin blocks the return
                if (st_ff.clk_ff)
                begin
                    nxt_st.act_ext_ff = pin_clock_select_i;
                    nxt_st.act_div_ff = clock_divide_field_i;
                end
            end
            else
            begin
                nxt_st.half_cnt_ff = st_ff.half_cnt_ff + 9'h001;
            end
        end
        unique case (st_ff.acq_ff)
            ecd_pkg::ECD_ACQ_IDLE:
            begin
                if (acq_start_i)
                begin
                    nxt_st.acq_ff = ecd_pkg::ECD_ACQ_BUSY;
                    nxt_st.acq_cnt_ff = acq_len;
                end
            end
            ecd_pkg::ECD_ACQ_BUSY:
            begin
                // counted in sampling periods, so length scales with the clock
                if (st_ff.tick_ff)
                begin
                    nxt_st.acq_cnt_ff = st_ff.acq_cnt_ff - 9'h001;
                    if (st_ff.acq_cnt_ff == 9'h001)
                    begin
                        nxt_st.acq_ff = ecd_pkg::ECD_ACQ_IDLE;
                        nxt_st.done_ff = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_ff <= '0;
            st_ff.osc_en_ff <= 1'b1;
            st_ff.pin_oe_ff <= 1'b1;
            st_ff.pin_out_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign sys_clk_o = st_ff.clk_ff;
    assign sys_tick_o = st_ff.tick_ff;
    assign acq_busy_o = (st_ff.acq_ff == ecd_pkg::ECD_ACQ_BUSY);
    assign acq_done_o = st_ff.done_ff;
    assign osc_enable_o = st_ff.osc_en_ff;
    assign sync_clock_irq_pin_oe_o = st_ff.pin_oe_ff;
    assign sync_clock_irq_pin_out_o = st_ff.pin_out_ff;

    // helper counters read only by the checks below
    logic [CNT_W-1:0] chk_cyc_ff;
    logic [CNT_W-1:0] chk_edge_ff;
    logic [CNT_W-1:0] chk_tick_ff;
    logic [CNT_W-1:0] chk_len_ff;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            chk_cyc_ff <= '0;
            chk_edge_ff <= '0;
            chk_tick_ff <= '0;
            chk_len_ff <= '0;
        end
        else
        begin
            chk_cyc_ff <= (st_ff.clk_ff != nxt_st.clk_ff) ? 9'h000 : chk_cyc_ff + 9'h001;
            chk_edge_ff <= (st_ff.clk_ff != nxt_st.clk_ff) ? 9'h000 : chk_edge_ff + CNT_W'(pin_rise);
            if (acq_start_i && !acq_busy_o)
            begin
                chk_tick_ff <= '0;
                chk_len_ff <= acq_len;
            end
            else if (acq_busy_o && sys_tick_o)
            begin
                chk_tick_ff <= chk_tick_ff + 9'h001;
            end
        end
    end

    localparam int OSC_HALF_I = `ECD_OSC_HALF_CYC;

    sequence ecd_toggle_s;
        $changed(sys_clk_o);
    endsequence

    osc_half_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ecd_toggle_s and ##0 !st_ff.act_ext_ff and ##0 !$past(st_ff.act_ext_ff)
        |-> $past(chk_cyc_ff) == CNT_W'(OSC_HALF_I - 1))
        else $error("nominal half period is not 250 cycles");

    ext_edge_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ecd_toggle_s and ##0 $past(st_ff.act_ext_ff) |-> $past(pin_rise))
        else $error("external derived clock moved without a pin edge");

    ext_count_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ecd_toggle_s and ##0 $past(st_ff.act_ext_ff)
        |-> $past(chk_edge_ff) == CNT_W'($past(st_ff.act_div_ff)))
        else $error("external half period edge count wrong");

    div_two_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        st_ff.act_ext_ff && st_ff.act_div_ff == '0 && pin_rise |=> $changed(sys_clk_o))
        else $error("divide by two does not toggle on every pin edge");

    cfg_fall_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        $changed(st_ff.act_ext_ff) || $changed(st_ff.act_div_ff) |-> $fell(sys_clk_o))
        else $error("clock source changed outside a falling edge");

    tick_rise_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        sys_tick_o == $rose(sys_clk_o))
        else $error("tick does not mark the derived rising edge");

    pin_dir_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        pin_clock_select_i |=> !sync_clock_irq_pin_oe_o && !osc_enable_o)
        else $error("select did not release pin and stop oscillator");

    acq_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        acq_done_o |-> chk_tick_ff == chk_len_ff)
        else $error("acquisition length differs from setting");

    acq_scale_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        acq_busy_o && !sys_tick_o |=> acq_busy_o && !acq_done_o)
        else $error("acquisition ended between sampling periods");

endmodule

// *** common/ecd_defines.svh ***
// constants for the sampling clock selector and divider
// assumes a 250 MHz core clock and a 500 kHz nominal sampling clock
`ifndef ECD_DEFINES_SVH
`define ECD_DEFINES_SVH

// core clock and nominal oscillator, in kHz
`define ECD_MCLK_KHZ 250000
`define ECD_OSC_KHZ 500

// mclk cycles per half period of the nominal sampling clock
`define ECD_OSC_HALF_CYC (`ECD_MCLK_KHZ / (2 * `ECD_OSC_KHZ))

// acquisition time at setting 3 and nominal period, in ns
`define ECD_ACQ3_TIME_NS 508000
`define ECD_NOM_PERIOD_NS (1000000 / `ECD_OSC_KHZ)

// acquisition length in sampling clock periods, per conversion setting
`define ECD_ACQ_TICKS_0 36
`define ECD_ACQ_TICKS_1 68
`define ECD_ACQ_TICKS_2 130
`define ECD_ACQ_TICKS_3 (`ECD_ACQ3_TIME_NS / `ECD_NOM_PERIOD_NS)

// default width of the clock divide field
`define ECD_DIV_W 2

`endif

// *** common/ecd_pkg.sv ***
// types shared by the sampling clock block
// assumes nothing of its surroundings
package ecd_pkg;

    // gray coded along idle -> busy
    typedef enum logic [0:0] {
        ECD_ACQ_IDLE = 1'b0,
        ECD_ACQ_BUSY = 1'b1
    } ecd_acq_e;

    typedef logic [1:0] ecd_setting_t;

endpackage

// *** hw/ecd_pin_sync.sv ***
// three stage synchroniser with a filtered level and rising edge pulse
// assumes the input is asynchronous to mclk_i
`timescale 1ns/100ps
module ecd_pin_sync (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);

    typedef struct packed {
        logic s1_ff;
        logic s2_ff;
        logic s3_ff;
        logic lvl_ff;
        logic rise_ff;
    } ecd_sync_s;

    ecd_sync_s st_ff;
    ecd_sync_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1_ff = async_i;
        nxt_st.s2_ff = st_ff.s1_ff;
        nxt_st.s3_ff = st_ff.s2_ff;
        nxt_st.rise_ff = 1'b0;
        // a change counts only once stages two and three agree
        if (st_ff.s2_ff == st_ff.s3_ff)
        begin
            nxt_st.lvl_ff = st_ff.s3_ff;
            nxt_st.rise_ff = st_ff.s3_ff & ~st_ff.lvl_ff;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        // the pin idles high on its pull-up, so no false edge follows reset
        if (!resetn_i)
            st_ff <= '{s1_ff: 1'b1, s2_ff: 1'b1, s3_ff: 1'b1, lvl_ff: 1'b1, rise_ff: 1'b0};
        else
            st_ff <= nxt_st;
    end

    assign level_o = st_ff.lvl_ff;
    assign rise_o = st_ff.rise_ff;

endmodule

// *** testbench/ecd_pin_source.sv ***
// model of the outside clock source that drives the shared pin
// assumes the bench picks the half period in mclk cycles
`timescale 1ns/100ps
module ecd_pin_source (
    input wire logic run_i,
    input wire logic [7:0] half_i,
    output logic pin_o,
    output logic drive_o
);
    // stands low between bursts; odd start offset keeps phase unrelated to mclk
    always
    begin
        if (run_i !== 1'b1)
        begin
            pin_o = 1'b0;
            @(posedge run_i);
            #1.3;
        end
        #(half_i * 4) pin_o = run_i & ~pin_o;
    end
    assign drive_o = run_i;
endmodule

// *** testbench/external_clock_divider_bench.sv ***
// self-checking bench for the sampling clock selector and divider
// assumes the design checks its own timing relations internally
`timescale 1ns/100ps
`include "ecd_defines.svh"
module external_clock_divider_bench;
    logic mclk_i, resetn_i, sel, irq, start, shunt, busy, done, tick;
    logic oe, pout, osc, sclk, src, drv, run;
    logic [1:0] field;
    logic [7:0] half;
    ecd_pkg::ecd_setting_t bset, sset;
    int err_total, total_checks, cyc, g, k;
    logic [15:0] lf;
    ecd_clock_divider #(.DIV_W(2)) i_ecd_clock_divider (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .pin_clock_select_i(sel), .clock_divide_field_i(field), .irq_req_i(irq),
        .sync_clock_irq_pin_in_i(oe ? pout : (drv ? src : 1'b1)), .acq_start_i(start),
        .acq_shunt_i(shunt), .bus_conversion_setting_i(bset), .shunt_conversion_setting_i(sset),
        .sync_clock_irq_pin_out_o(pout), .sync_clock_irq_pin_oe_o(oe), .osc_enable_o(osc),
        .sys_clk_o(sclk), .sys_tick_o(tick), .acq_busy_o(busy), .acq_done_o(done));
    ecd_pin_source i_ecd_pin_source (.run_i(run), .half_i(half), .pin_o(src), .drive_o(drv));
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic int exp_ticks(input logic [1:0] s);
        case (s)
            2'h0: return `ECD_ACQ_TICKS_0;
            2'h1: return `ECD_ACQ_TICKS_1;
            2'h2: return `ECD_ACQ_TICKS_2;
            default: return `ECD_ACQ_TICKS_3;
        endcase
    endfunction
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // gap between sys ticks, taken on the third so config changes have settled
    task automatic tick_gap(output int n);
        repeat (3)
        begin
            n = 0;
            do
            begin
                step(1);
                n++;
            end while (tick !== 1'b1);
        end
        chk("clk_hi", 1, sclk);
    endtask
    task automatic acq(input logic ch, input logic [1:0] b, input logic [1:0] s, input int p);
        int n, t, c;
        n = exp_ticks(ch ? s : b);
        t = 0;
        c = 0;
        @(posedge mclk_i);
        shunt <= ch;
        bset <= b;
        sset <= s;
        start <= 1'b1;
        // sampling begins at the edge that takes start, so a tick launched there counts
        do
        begin
            @(posedge mclk_i);
            // a start while busy must be ignored
            start <= (c == 4);
            #1;
            c++;
            if (busy === 1'b1 && tick === 1'b1)
                t++;
        end while (done !== 1'b1);
        chk("acq_ticks", n, t);
        chk("acq_len_ok", 1, c >= (n - 1) * p && c <= n * p + 8);
        chk("busy_end", 0, busy);
    endtask
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 95000)
        begin
            err_total++;
            stop_test();
        end
    end
    initial
    begin
        {sel, irq, start, shunt, run, field, bset, sset} = '0;
        half = 8'h08;
        err_total = 0;
        total_checks = 0;
        lf = 16'hd1fc;
        resetn_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        step(1);
        chk("oe_rst", 1, oe);
        chk("osc_rst", 1, osc);
        tick_gap(g);
        chk("int_gap", 2 * `ECD_OSC_HALF_CYC, g);
        for (k = 0; k < 8; k++)
        begin
            lf = lfsr_next(lf);
            @(posedge mclk_i);
            irq <= lf[0];
            step(2);
            chk("pin_out", !lf[0], pout);
        end
        @(posedge mclk_i);
        irq <= 1'b0;
        half <= 8'h7d;
        run <= 1'b1;
        sel <= 1'b1;
        step(2);
        chk("oe_ext", 0, oe);
        chk("osc_ext", 0, osc);
        tick_gap(g);
        chk("div2_gap", 2 * `ECD_OSC_HALF_CYC, g);
        // fast pin keeps the long acquisitions inside the cycle budget
        @(posedge mclk_i);
        half <= 8'h08;
        for (k = 0; k < 4; k++)
        begin
            @(posedge mclk_i);
            field <= k[1:0];
            tick_gap(g);
            chk("ext_gap", 32 * (k + 1), g);
        end
        acq(1'b0, 2'h3, 2'h0, 128);
        @(posedge mclk_i);
        field <= 2'h0;
        tick_gap(g);
        chk("ext_gap", 32, g);
        acq(1'b1, 2'h0, 2'h3, 32);
        for (k = 0; k < 4; k++)
        begin
            lf = lfsr_next(lf);
            acq(lf[0], lf[2:1], lf[4:3], 32);
        end
        // pin near 3.9 MHz divided by eight stays inside the recommended rates
        @(posedge mclk_i);
        half <= 8'h20;
        field <= 2'h3;
        tick_gap(g);
        chk("legal_gap", 512, g);
        stop_test();
    end
endmodule
